// ---- core/clr_top.sv ----
// Purpose: quad channel link control, link fault status and device reset
// Assumes: clk is the reference clock; pins are asynchronous
// Notes: enable latches are transparent while their open input is high
// Functional notes
// - loopback routes a channel's transmit stream into its own receive recovery path
// - during loopback serial output holds one and external input is ignored
// - link fault low on bad frequency, low amplitude, low density or disabled receive
// - three-level select picks one of three amplitude thresholds for valid signal
// - reset sampled low clears state machines, counters, sets elasticity pointers nominal
// - outputs deterministic within fewer than 16 reference cycles after reset release
// - reset also clears output-enable and receive enable latches and sets the self-test latch to all ones
// - reset disables all drivers outside loopback (loopback still holds serial output one), all self-test and all receive channels
`timescale 1ns/10ps
`default_nettype none
module clr_top #(
    parameter int CHANNELS = clr_pkg::CLR_CHANNELS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // device reset pin, active low
    input wire logic device_reset_n,
    // configuration pins
    input wire clr_pkg::clr_amp_sel_e amplitude_threshold_select,
    input wire logic [CHANNELS-1:0] channel_loopback_enable,
    input wire logic [clr_pkg::CLR_ENABLE_BITS-1:0] enable_bus,
    input wire logic output_enable_latch_open,
    input wire logic selftest_latch_open,
    input wire logic receive_enable_latch_open,
    // serial data
    input wire logic [CHANNELS-1:0] tx_serial,
    input wire clr_pkg::clr_rx_obs_s [CHANNELS-1:0] rx_obs,
    // status and results
    output logic [CHANNELS-1:0] serial_out,
    output logic [CHANNELS-1:0] cdr_data,
    output logic [CHANNELS-1:0] channel_link_fault_n,
    output clr_pkg::clr_latches_s latches,
    output logic [clr_pkg::CLR_EB_BITS-1:0] elastic_ptr,
    output logic ready
);
    import clr_pkg::*;

    // elaboration check: the logic serves exactly four channels
    if (CHANNELS != CLR_CHANNELS) begin : g_bad_channels
        $error("clr_top: CHANNELS must be 4");
    end

    // *********************************************
    // pin synchronisers
    // *********************************************
    localparam int SYNC_W = 4 + CHANNELS + CLR_ENABLE_BITS + 2;
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    wire logic [SYNC_W-1:0] pins_raw;
    assign pins_raw = {device_reset_n, output_enable_latch_open, selftest_latch_open,
                       receive_enable_latch_open, channel_loopback_enable, enable_bus,
                       amplitude_threshold_select};
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pins_raw;
            sync_r <= meta_r;
        end
    end

    wire logic dev_rst_s;
    wire logic oe_open_s;
    wire logic bist_open_s;
    wire logic rx_open_s;
    wire logic [CHANNELS-1:0] loop_s;
    wire logic [CLR_ENABLE_BITS-1:0] bus_s;
    wire logic [1:0] sel_s;
    assign {dev_rst_s, oe_open_s, bist_open_s, rx_open_s, loop_s, bus_s, sel_s} = sync_r;

    // combined reset: system reset or device reset sampled low
    wire logic core_rstn;
    assign core_rstn = resetn & dev_rst_s;

    // *********************************************
    // threshold select
    // *********************************************
    function automatic logic [CLR_AMP_BITS-1:0] amp_of(input logic [1:0] sel);
        case (sel)
            CLR_SEL_LOW: amp_of = CLR_AMP_LOW;
            CLR_SEL_MID: amp_of = CLR_AMP_MID;
            CLR_SEL_HIGH: amp_of = CLR_AMP_HIGH;
            default: amp_of = CLR_AMP_MID;
        endcase
    endfunction
    wire logic [CLR_AMP_BITS-1:0] amp_thr;
    assign amp_thr = amp_of(sel_s);

    // *********************************************
    // enable latches
    // *********************************************
    clr_latches_s lat_r;
    clr_latches_s lat_nxt;
    always_comb begin
        lat_nxt = lat_r;
        if (oe_open_s) begin
            lat_nxt.output_en = bus_s;
        end
        if (bist_open_s) begin
            lat_nxt.selftest_n = bus_s;
        end
        if (rx_open_s) begin
            lat_nxt.receive_en = bus_s;
        end
    end
    always_ff @(posedge clk) begin
        if (!core_rstn) begin
            lat_r.output_en <= CLR_ENABLES_RESET;
            lat_r.selftest_n <= CLR_BIST_RESET;
            lat_r.receive_en <= CLR_ENABLES_RESET;
        end else begin
            lat_r <= lat_nxt;
        end
    end

    // *********************************************
    // reset sequencing
    // *********************************************
    clr_state_e state_r;
    logic [CLR_CNT_BITS-1:0] cnt_r;
    logic [CLR_EB_BITS-1:0] ptr_r;
    always_ff @(posedge clk) begin
        if (!core_rstn) begin
            state_r <= CLR_ST_RESET;
            cnt_r <= 4'h0;
            ptr_r <= CLR_EB_NOMINAL;
        end else begin
            case (state_r)
                CLR_ST_RESET: begin
                    state_r <= CLR_ST_SETTLE;
                end
                CLR_ST_SETTLE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(CLR_READY_CYCLES - 4)) begin
                        state_r <= CLR_ST_RUN;
                    end
                end
                CLR_ST_RUN: begin
                    ptr_r <= ptr_r;
                end
                default: begin
                    state_r <= CLR_ST_RESET;
                end
            endcase
        end
    end

    // *********************************************
    // channels
    // *********************************************
    wire logic [CHANNELS-1:0] ch_out;
    wire logic [CHANNELS-1:0] ch_cdr;
    wire logic [CHANNELS-1:0] ch_fault_n;
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            clr_chan u_chan (
                .clk(clk),
                .resetn(core_rstn),
                .loopback_en(loop_s[g]),
                .rx_enable(lat_r.receive_en[2*g]),
                .tx_enable(lat_r.output_en[2*g]),
                .amp_threshold(amp_thr),
                .tx_serial(tx_serial[g]),
                .rx_obs(rx_obs[g]),
                .serial_out(ch_out[g]),
                .cdr_data(ch_cdr[g]),
                .fault_n(ch_fault_n[g])
            );
        end
    endgenerate

    // *********************************************
    // output registers
    // *********************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            serial_out <= '0;
            cdr_data <= '0;
            channel_link_fault_n <= '0;
            latches <= '0;
            elastic_ptr <= CLR_EB_NOMINAL;
            ready <= 1'b0;
        end else begin
            serial_out <= ch_out;
            cdr_data <= ch_cdr;
            channel_link_fault_n <= ch_fault_n;
            latches <= lat_r;
            elastic_ptr <= ptr_r;
            ready <= (state_r == CLR_ST_RUN);
        end
    end
endmodule
`default_nettype wire

// ---- core/clr_pkg.sv ----
// Purpose: shared constants and carriers for channel link control and reset
// Assumes: four channels, one reference clock domain
// Notes: thresholds are plain codes, no analog figures
package clr_pkg;
    localparam int CLR_CHANNELS = 4;
    localparam int CLR_ENABLE_BITS = 8;
    localparam int CLR_AMP_BITS = 8;
    // ready time after reset release, in reference clock cycles
    localparam int CLR_READY_CYCLES = 15;
    localparam int CLR_CNT_BITS = 4;
    // elasticity pointer nominal offset
    localparam logic [3:0] CLR_EB_NOMINAL = 4'h8;
    localparam int CLR_EB_BITS = 4;
    // amplitude trip points per select level
    localparam logic [7:0] CLR_AMP_LOW = 8'h10;
    localparam logic [7:0] CLR_AMP_MID = 8'h40;
    localparam logic [7:0] CLR_AMP_HIGH = 8'h80;
    // transition density floor per observation window
    localparam logic [7:0] CLR_DENSITY_MIN = 8'h04;
    localparam logic [7:0] CLR_WINDOW_LEN = 8'h3f;
    localparam logic [7:0] CLR_ENABLES_RESET = 8'h00;
    localparam logic [7:0] CLR_BIST_RESET = 8'hff;

    typedef enum logic [1:0] {
        CLR_SEL_LOW = 2'b00,
        CLR_SEL_MID = 2'b01,
        CLR_SEL_HIGH = 2'b10
    } clr_amp_sel_e;

    typedef enum logic [1:0] {
        CLR_ST_RESET = 2'b00,
        CLR_ST_SETTLE = 2'b01,
        CLR_ST_RUN = 2'b10
    } clr_state_e;

    // per-channel receive observations
    typedef struct packed {
        logic freq_ok;
        logic [7:0] amplitude;
        logic serial_in;
    } clr_rx_obs_s;

    // latched enables
    typedef struct packed {
        logic [7:0] output_en;
        logic [7:0] selftest_n;
        logic [7:0] receive_en;
    } clr_latches_s;
endpackage

// ---- core/clr_chan.sv ----
// Purpose: one channel's loopback routing and link fault monitor
// Assumes: inputs already synchronised to clk
// Notes: density counted as edges per fixed window
`timescale 1ns/10ps
`default_nettype none
module clr_chan (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // controls
    input wire logic loopback_en,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic [clr_pkg::CLR_AMP_BITS-1:0] amp_threshold,
    // serial data
    input wire logic tx_serial,
    input wire clr_pkg::clr_rx_obs_s rx_obs,
    // results
    output logic serial_out,
    output logic cdr_data,
    output logic fault_n
);
    import clr_pkg::*;

    logic prev_r;
    logic [7:0] win_r;
    logic [7:0] edges_r;
    logic density_low_r;
    wire logic cdr_in;
    wire logic edge_seen;
    wire logic amp_low;
    wire logic any_fault;

    assign cdr_in = loopback_en ? tx_serial : rx_obs.serial_in;
    assign edge_seen = cdr_in ^ prev_r;
    assign amp_low = !loopback_en && (rx_obs.amplitude < amp_threshold);
    assign any_fault = (!loopback_en && !rx_obs.freq_ok) || amp_low
                       || density_low_r || !rx_enable;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prev_r <= 1'b0;
            win_r <= 8'h00;
            edges_r <= 8'h00;
            density_low_r <= 1'b1;
            serial_out <= 1'b0;
            cdr_data <= 1'b0;
            fault_n <= 1'b0;
        end else begin
            prev_r <= cdr_in;
            cdr_data <= cdr_in;
            serial_out <= loopback_en ? 1'b1 : (tx_enable & tx_serial);
            fault_n <= !any_fault;
            if (win_r == CLR_WINDOW_LEN) begin
                win_r <= 8'h00;
                edges_r <= 8'h00;
                density_low_r <= (edges_r < CLR_DENSITY_MIN);
            end else begin
                win_r <= win_r + 8'h01;
                if (edge_seen && edges_r != 8'hff) begin
                    edges_r <= edges_r + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/clr_host.sv ----
// Purpose: host side model driving reset and enable latch pins
// Assumes: pins change on the falling clock edge
// Notes: bus value flipped four cycles after the latches close
`timescale 1ns/10ps
`default_nettype none
module clr_host (
    // clock
    input wire logic clk,
    // host pins
    output logic device_reset_n,
    output logic [7:0] enable_bus,
    output logic output_enable_latch_open,
    output logic selftest_latch_open,
    output logic receive_enable_latch_open
);
    import clr_pkg::*;
    initial begin
        device_reset_n = 1'b0;
        enable_bus = CLR_ENABLES_RESET;
        {output_enable_latch_open, selftest_latch_open, receive_enable_latch_open} = 3'h0;
    end
    task automatic set_reset(input logic v);
        @(negedge clk);
        device_reset_n = v;
    endtask
    // which: output, selftest, receive latch opens
    task automatic load(input logic [7:0] v, input logic [2:0] which);
        @(negedge clk);
        enable_bus = v;
        {output_enable_latch_open, selftest_latch_open, receive_enable_latch_open} = which;
        repeat (4) @(negedge clk);
        {output_enable_latch_open, selftest_latch_open, receive_enable_latch_open} = 3'h0;
        repeat (4) @(negedge clk);
        enable_bus = ~v;
    endtask
endmodule
`default_nettype wire

// ---- tb/clr_top_sva.sv ----
// Purpose: port checks of loopback, link fault and device reset
// Assumes: one clock, resetn synchronous active low
// Notes: history kept in small helper registers
`timescale 1ns/10ps
`default_nettype none
module clr_top_sva #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic device_reset_n,
    input wire clr_pkg::clr_amp_sel_e amplitude_threshold_select,
    input wire logic [CHANNELS-1:0] channel_loopback_enable,
    input wire logic [CHANNELS-1:0] tx_serial,
    input wire clr_pkg::clr_rx_obs_s [CHANNELS-1:0] rx_obs,
    input wire logic [CHANNELS-1:0] serial_out,
    input wire logic [CHANNELS-1:0] cdr_data,
    input wire logic [CHANNELS-1:0] channel_link_fault_n,
    input wire clr_pkg::clr_latches_s latches,
    input wire logic [clr_pkg::CLR_EB_BITS-1:0] elastic_ptr,
    input wire logic ready
);
    import clr_pkg::*;
    logic [CHANNELS-1:0] lp1, lp2, lp3, lp4, si, si1, fbad, abad, good;
    logic [7:0] run_cnt, dr_cnt, good_cnt;
    wire [CHANNELS-1:0] lp_on = channel_loopback_enable & lp1 & lp2 & lp3 & lp4;
    wire [CHANNELS-1:0] lp_off = ~(channel_loopback_enable | lp1 | lp2 | lp3 | lp4);
    wire clr_amp_sel_e sel = amplitude_threshold_select;
    wire [7:0] thr = (sel == CLR_SEL_LOW) ? CLR_AMP_LOW :
        ((sel == CLR_SEL_HIGH) ? CLR_AMP_HIGH : CLR_AMP_MID);
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        assign si[g] = rx_obs[g].serial_in;
        assign fbad[g] = !rx_obs[g].freq_ok;
        assign abad[g] = rx_obs[g].amplitude < thr;
        assign good[g] = !fbad[g] && !abad[g] && latches.receive_en[2*g] && si[g] != si1[g];
    end
    always_ff @(posedge clk) begin
        {lp4, lp3, lp2, lp1, si1} <= {lp3, lp2, lp1, channel_loopback_enable, si};
    end
    always_ff @(posedge clk) begin
        if (!resetn || !device_reset_n) begin
            run_cnt <= 8'h00;
            good_cnt <= 8'h00;
        end else begin
            run_cnt <= run_cnt + 8'(run_cnt != 8'hff);
            good_cnt <= (&(good & lp_off)) ? good_cnt + 8'(good_cnt != 8'hff) : 8'h00;
        end
        dr_cnt <= (!resetn || device_reset_n) ? 8'h00 : dr_cnt + 8'(dr_cnt != 8'hff);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    loop_out_a: assert property (run_cnt > 8'h08 |-> (lp_on & ~serial_out) == '0)
        else $error("serial output not one in loopback");
    loop_cdr_a: assert property (run_cnt > 8'h08 |->
        ((cdr_data ^ $past(tx_serial, 2)) & lp_on) == '0)
        else $error("loopback recovery path not fed from transmit");
    freq_fault_a: assert property (($past(fbad, 2) & $past(lp_off, 2) & channel_link_fault_n) == '0)
        else $error("link fault missing on bad frequency");
    amp_fault_a: assert property ($past(sel, 4) == sel && $past(sel, 2) == sel |->
        ($past(abad, 2) & $past(lp_off, 2) & channel_link_fault_n) == '0)
        else $error("link fault missing on low amplitude");
    fault_clear_a: assert property (good_cnt > 8'h60 |-> channel_link_fault_n == '1)
        else $error("link fault stays low without cause");
    reset_latch_a: assert property (dr_cnt > 8'h04 |->
        latches == {CLR_ENABLES_RESET, CLR_BIST_RESET, CLR_ENABLES_RESET})
        else $error("latches not cleared by device reset");
    reset_ptr_a: assert property (dr_cnt > 8'h04 |-> elastic_ptr == CLR_EB_NOMINAL && !ready)
        else $error("pointer not nominal during device reset");
    ready_time_a: assert property ($rose(device_reset_n) && dr_cnt > 8'h04 |-> ##[1:18] ready)
        else $error("ready late after device reset");
    cover property (|lp_on);
    cover property (dr_cnt == 8'h05);
    cover property ($rose(ready));
    cover property (good_cnt == 8'h61);
endmodule
`default_nettype wire

// ---- tb/channel_link_control_reset_bench.sv ----
// Purpose: self-checking bench for clr_top
// Assumes: inputs change on falling edges, outputs read there
// Notes: notes queue holds due cycle, output kind and expected value
`timescale 1ns/10ps
`default_nettype none
module channel_link_control_reset_bench;
    import clr_pkg::*;
    typedef struct {int due; int kind; logic [23:0] val;} clr_note_s;
    logic clk = 0, resetn = 0, dev_n, oe_o, st_o, rx_o, rdy;
    logic [7:0] ebus;
    clr_amp_sel_e sel = CLR_SEL_LOW;
    logic [3:0] lp = 0, tx = 0, sout, cdr, fault_n, ptr;
    clr_rx_obs_s [3:0] obs = '0;
    clr_latches_s lat;
    int cyc = 0, n_fail = 0, cmp_count = 0, seed = 32'h7a56c276;
    clr_note_s q[$];
    initial forever #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    clr_host host (.clk(clk), .device_reset_n(dev_n), .enable_bus(ebus),
        .output_enable_latch_open(oe_o), .selftest_latch_open(st_o),
        .receive_enable_latch_open(rx_o));
    clr_top #(.CHANNELS(4)) dut (.clk(clk), .resetn(resetn), .device_reset_n(dev_n),
        .amplitude_threshold_select(sel), .channel_loopback_enable(lp), .enable_bus(ebus),
        .output_enable_latch_open(oe_o), .selftest_latch_open(st_o),
        .receive_enable_latch_open(rx_o), .tx_serial(tx), .rx_obs(obs), .serial_out(sout),
        .cdr_data(cdr), .channel_link_fault_n(fault_n), .latches(lat), .elastic_ptr(ptr),
        .ready(rdy));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input int d, input int k, input logic [23:0] v);
        q.push_back('{cyc + d, k, v});
    endtask
    function automatic logic [23:0] pick(input int k);
        case (k)
            0: return fault_n;
            1: return sout;
            2: return cdr;
            3: return lat;
            4: return ptr;
            default: return rdy;
        endcase
    endfunction
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            check(pick(q[0].kind), q[0].val);
            void'(q.pop_front());
        end
    end
    task automatic run(input int n, input logic [3:0] dens, input bit chk);
        logic [3:0] s;
        repeat (n) begin
            @(negedge clk);
            tx = 4'($random(seed));
            for (int g = 0; g < 4; g++) begin
                obs[g].serial_in = dens[g] & ~obs[g].serial_in;
                s[g] = obs[g].serial_in;
            end
            if (chk) begin
                note(2, 1, lp | tx);
                note(2, 2, (tx & lp) | (s & ~lp));
            end
        end
    endtask
    task automatic expect_f(input logic [3:0] bad);
        repeat (3) @(negedge clk);
        // concatenation keeps the inversion at four bits
        note(1, 0, {20'h0, ~bad});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (7) @(negedge clk);
        note(1, 3, 24'h0);
        note(1, 4, CLR_EB_NOMINAL);
        @(negedge clk);
        resetn = 1;
        repeat (6) @(negedge clk);
        note(1, 3, {8'h00, 8'hff, 8'h00});
        note(1, 4, CLR_EB_NOMINAL);
        host.set_reset(1);
        repeat (17) @(negedge clk);
        note(1, 5, 1);
        note(1, 0, 0);
        host.load(8'h55, 3'b101);
        note(1, 3, {8'h55, 8'hff, 8'h55});
        for (int g = 0; g < 4; g++) obs[g] = '{1'b1, 8'hc0 | 8'($random(seed)), 1'b0};
        run(200, 4'hf, 1);
        expect_f(4'h0);
        for (int g = 0; g < 4; g++) begin
            obs[g].freq_ok = 0;
            run(20, 4'hf, 0);
            expect_f(4'(1 << g));
            obs[g] = '{1'b1, 8'h30, obs[g].serial_in};
            for (int s = 0; s < 3; s++) begin
                sel = clr_amp_sel_e'(s);
                run(10, 4'hf, 0);
                expect_f(s == 0 ? 4'h0 : 4'(1 << g));
            end
            obs[g].amplitude = 8'hd0;
            run(150, ~4'(1 << g), 0);
            expect_f(4'(1 << g));
            // density restored first so only the disabled receive can fault
            run(150, 4'hf, 0);
            host.load(8'h55 ^ 8'(1 << (2 * g)), 3'b001);
            expect_f(4'(1 << g));
            host.load(8'h55, 3'b001);
            run(200, 4'hf, 0);
            expect_f(4'h0);
        end
        lp = 4'b0101;
        for (int g = 0; g < 4; g++) obs[g].freq_ok = 0;
        run(10, 4'hf, 0);
        run(150, 4'hf, 1);
        expect_f(4'b1010);
        host.set_reset(0);
        repeat (6) @(negedge clk);
        note(1, 3, {8'h00, 8'hff, 8'h00});
        note(1, 4, CLR_EB_NOMINAL);
        host.set_reset(1);
        repeat (18) @(negedge clk);
        note(1, 5, 1);
        repeat (3) @(negedge clk);
        complete_run();
    end
endmodule
bind clr_top clr_top_sva #(.CHANNELS(CHANNELS)) u_sva (.clk(clk), .resetn(resetn),
    .device_reset_n(device_reset_n), .amplitude_threshold_select(amplitude_threshold_select),
    .channel_loopback_enable(channel_loopback_enable), .tx_serial(tx_serial),
    .rx_obs(rx_obs), .serial_out(serial_out), .cdr_data(cdr_data),
    .channel_link_fault_n(channel_link_fault_n), .latches(latches),
    .elastic_ptr(elastic_ptr), .ready(ready));
`default_nettype wire
